// ### ppd_pkg.sv
// Package for the parallel port data register block: modes, widths, reset values, carriers.
// Assumes a single system clock domain and a sequencing block that issues strobes.
package ppd_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Widths and field positions
	localparam int BYTE_W    = 8;
	localparam int WORD_W    = 16;
	localparam int CS_W      = 2;
	localparam int CS_LSB    = 14;
	localparam int ADDR_HI_W = 8;
	localparam logic [7:0]  BYTE_RST = 8'h00;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [1:0]  CS_IDLE  = 2'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Operating mode and register selects
	typedef enum logic [1:0] {
		PPD_MODE_SLAVE,
		PPD_MODE_BUF_SLAVE,
		PPD_MODE_MASTER
	} ppd_mode_t;

	typedef enum logic [2:0] {
		PPD_SEL_IN_A_LO,
		PPD_SEL_IN_A_HI,
		PPD_SEL_IN_B_LO,
		PPD_SEL_IN_B_HI,
		PPD_SEL_SHARED_LO,
		PPD_SEL_SHARED_HI,
		PPD_SEL_OUT_B_LO,
		PPD_SEL_OUT_B_HI
	} ppd_sel_t;

	// Core side byte access
	typedef struct packed {
		logic             wr;
		logic             rd;
		ppd_sel_t         sel;
		logic [7:0]       wdata;
	} ppd_core_req_t;

	// Bus side strobes from the sequencer
	typedef struct packed {
		logic             rx_wr;   // bus data arrived
		logic             rx_word; // 16-bit bus
		logic             tx_rd;   // host read / master write beat
		logic             cs_en;   // chip-select configuration
		logic [15:0]      rx_data;
	} ppd_bus_req_t;

	// Registered state
	typedef struct packed {
		logic [15:0]      in_a;
		logic [15:0]      in_b;
		logic [15:0]      shared;
		logic [15:0]      out_b;
		logic             rx_b_next; // next receive goes to pair B
		logic             tx_b_next; // next transmit from pair B
		logic [7:0]       rdata;
		logic [15:0]      tx_data;
	} ppd_state_t;

endpackage

// ### ppd_data_regs.sv
// Data register file of the parallel port: four byte pairs between core and bus.
// Assumes mode, chip-select setup and bus strobes come from the port sequencer on CLK_SYS_I.
`timescale 1ns/100ps

module ppd_data_regs (
	input  wire logic                    CLK_SYS_I,   // 40 MHz system clock
	input  wire logic                    RESETN_I,    // Async reset, active low
	input  wire ppd_pkg::ppd_mode_t      MODE_I,      // Current operating mode
	input  wire ppd_pkg::ppd_core_req_t  CORE_REQ_I,  // Core byte read/write
	input  wire ppd_pkg::ppd_bus_req_t   BUS_REQ_I,   // Sequencer bus strobes
	output logic [7:0]                   CORE_RDATA_O, // Core read data, registered
	output logic [15:0]                  BUS_ADDR_O,  // Master bus address
	output logic [1:0]                   BUS_CS_O,    // Chip selects, active high
	output logic [15:0]                  BUS_TXDATA_O // Outgoing bus data, registered
);

	////////////////////////////////////////////////////////////////////////////////
	// State
	ppd_pkg::ppd_state_t st_reg;
	ppd_pkg::ppd_state_t st_next;

	logic is_master;
	logic is_buf;

	// Mode decode
	assign is_master = (MODE_I == ppd_pkg::PPD_MODE_MASTER);
	assign is_buf    = (MODE_I == ppd_pkg::PPD_MODE_BUF_SLAVE);

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		st_next = st_reg;
		// Core write, byte granular so 16-bit moves are two writes
		if (CORE_REQ_I.wr) begin
			unique case (CORE_REQ_I.sel)
				ppd_pkg::PPD_SEL_IN_A_LO:   st_next.in_a[7:0]    = CORE_REQ_I.wdata;
				ppd_pkg::PPD_SEL_IN_A_HI:   st_next.in_a[15:8]   = CORE_REQ_I.wdata;
				ppd_pkg::PPD_SEL_IN_B_LO:   st_next.in_b[7:0]    = CORE_REQ_I.wdata;
				ppd_pkg::PPD_SEL_IN_B_HI:   st_next.in_b[15:8]   = CORE_REQ_I.wdata;
				// One storage for address and output A, any mode
				ppd_pkg::PPD_SEL_SHARED_LO: st_next.shared[7:0]  = CORE_REQ_I.wdata;
				ppd_pkg::PPD_SEL_SHARED_HI: st_next.shared[15:8] = CORE_REQ_I.wdata;
				ppd_pkg::PPD_SEL_OUT_B_LO:  st_next.out_b[7:0]   = CORE_REQ_I.wdata;
				ppd_pkg::PPD_SEL_OUT_B_HI:  st_next.out_b[15:8]  = CORE_REQ_I.wdata;
			endcase
		end
		// Core read returns stored value, same for both aliases
		if (CORE_REQ_I.rd) begin
			unique case (CORE_REQ_I.sel)
				ppd_pkg::PPD_SEL_IN_A_LO:   st_next.rdata = st_reg.in_a[7:0];
				ppd_pkg::PPD_SEL_IN_A_HI:   st_next.rdata = st_reg.in_a[15:8];
				ppd_pkg::PPD_SEL_IN_B_LO:   st_next.rdata = st_reg.in_b[7:0];
				ppd_pkg::PPD_SEL_IN_B_HI:   st_next.rdata = st_reg.in_b[15:8];
				ppd_pkg::PPD_SEL_SHARED_LO: st_next.rdata = st_reg.shared[7:0];
				ppd_pkg::PPD_SEL_SHARED_HI: st_next.rdata = st_reg.shared[15:8];
				ppd_pkg::PPD_SEL_OUT_B_LO:  st_next.rdata = st_reg.out_b[7:0];
				ppd_pkg::PPD_SEL_OUT_B_HI:  st_next.rdata = st_reg.out_b[15:8];
			endcase
		end
		// Bus receive; bus wins over a same-cycle core write
		if (BUS_REQ_I.rx_wr) begin
			if (is_buf && st_reg.rx_b_next) begin
				st_next.in_b      = BUS_REQ_I.rx_data;
				st_next.rx_b_next = 1'b0;
			end else begin
				st_next.in_a      = BUS_REQ_I.rx_data;
				st_next.rx_b_next = is_buf;
			end
			// 8-bit bus leaves the high byte untouched
			if (!BUS_REQ_I.rx_word) begin
				if (is_buf && st_reg.rx_b_next)
					st_next.in_b[15:8] = st_reg.in_b[15:8];
				else
					st_next.in_a[15:8] = st_reg.in_a[15:8];
			end
		end
		// Bus transmit data select
		if (BUS_REQ_I.tx_rd) begin
			if (is_master) begin
				st_next.tx_data = st_reg.in_a;
			end else if (is_buf && st_reg.tx_b_next) begin
				st_next.tx_data   = st_reg.out_b;
				st_next.tx_b_next = 1'b0;
			end else begin
				st_next.tx_data   = st_reg.shared;
				st_next.tx_b_next = is_buf;
			end
		end
		// Leaving buffered slave restarts both ping-pongs at pair A
		if (!is_buf) begin
			st_next.rx_b_next = 1'b0;
			st_next.tx_b_next = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			st_reg <= '{in_a: ppd_pkg::WORD_RST, in_b: ppd_pkg::WORD_RST,
				shared: ppd_pkg::WORD_RST, out_b: ppd_pkg::WORD_RST,
				rx_b_next: 1'b0, tx_b_next: 1'b0,
				rdata: ppd_pkg::BYTE_RST, tx_data: ppd_pkg::WORD_RST};
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs; address only meaningful in master mode, held at zero otherwise
	always_comb begin
		BUS_ADDR_O = ppd_pkg::WORD_RST;
		BUS_CS_O   = ppd_pkg::CS_IDLE;
		if (is_master) begin
			BUS_ADDR_O = st_reg.shared;
			if (BUS_REQ_I.cs_en) begin
				// Top bits become chip selects, not address
				BUS_CS_O = st_reg.shared[ppd_pkg::CS_LSB +: ppd_pkg::CS_W];
				BUS_ADDR_O[ppd_pkg::CS_LSB +: ppd_pkg::CS_W] = ppd_pkg::CS_IDLE;
			end
		end
	end

	assign CORE_RDATA_O = st_reg.rdata;
	assign BUS_TXDATA_O = st_reg.tx_data;

endmodule

// ### ppd_props.sv
// Checker for the data register block, watching its ports only.
// Assumes it is bound onto ppd_data_regs by the bench.
`timescale 1ns/100ps
module ppd_props (
	input wire logic                   CLK_SYS_I,    // Clock
	input wire logic                   RESETN_I,     // Reset, active low
	input wire ppd_pkg::ppd_mode_t     MODE_I,       // Mode
	input wire ppd_pkg::ppd_core_req_t CORE_REQ_I,   // Core access
	input wire ppd_pkg::ppd_bus_req_t  BUS_REQ_I,    // Bus strobes
	input wire logic [7:0]             CORE_RDATA_O, // Read data
	input wire logic [15:0]            BUS_ADDR_O,   // Address
	input wire logic [1:0]             BUS_CS_O,     // Chip selects
	input wire logic [15:0]            BUS_TXDATA_O  // Outgoing data
);
	// One domain, so one clock and reset serve all
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (!RESETN_I);
	logic m, c, w, wl, wh, r;
	// Short names keep the properties on a line
	assign m  = MODE_I == ppd_pkg::PPD_MODE_MASTER;
	assign c  = BUS_REQ_I.cs_en;
	assign w  = CORE_REQ_I.wr;
	assign r  = BUS_REQ_I.rx_wr;
	assign wl = w && CORE_REQ_I.sel == ppd_pkg::PPD_SEL_SHARED_LO;
	assign wh = w && CORE_REQ_I.sel == ppd_pkg::PPD_SEL_SHARED_HI;
	////////////////////////////////////////
	addr_idle_a: assert property (!m |-> BUS_ADDR_O == 16'h0000 && BUS_CS_O == 2'h0)
		else $error("address outside master");
	cs_bits_a: assert property (m && c |-> BUS_ADDR_O[15:14] == 2'h0)
		else $error("select bits in address");
	cs_off_a: assert property (!c |-> BUS_CS_O == 2'h0)
		else $error("selects without setup");
	addr_low_a: assert property (wl && m ##1 m |-> BUS_ADDR_O[7:0] == $past(CORE_REQ_I.wdata))
		else $error("low address wrong");
	addr_high_a: assert property (wh && m && !c ##1 m && !c |-> BUS_ADDR_O[15:8] == $past(CORE_REQ_I.wdata))
		else $error("high address wrong");
	cs_set_a: assert property (wh ##1 m && c |-> BUS_CS_O == $past(CORE_REQ_I.wdata[7:6]))
		else $error("chip selects wrong");
	rd_hold_a: assert property (!CORE_REQ_I.rd |=> $stable(CORE_RDATA_O))
		else $error("read data moved");
	tx_hold_a: assert property (!BUS_REQ_I.tx_rd |=> $stable(BUS_TXDATA_O))
		else $error("outgoing data moved");
	tx_master_a: assert property (m && r && BUS_REQ_I.rx_word && !w ##1 m && !r && !w ##1 m && BUS_REQ_I.tx_rd
		|=> BUS_TXDATA_O == $past(BUS_REQ_I.rx_data, 3))
		else $error("master echo wrong");
endmodule

// ### ppd_host.sv
// Far side bus model: raises bus strobes and data toward the block.
// Assumes its tasks are called at the falling clock edge.
`timescale 1ns/100ps
module ppd_host (
	input  wire logic             clk_i, // System clock
	output ppd_pkg::ppd_bus_req_t bus_o  // Strobes to the block
);
	initial bus_o = '0;
	// Idle data is the inverse of the last word, so stale data never matches
	task rx(input logic w, input logic [15:0] d);
		@(negedge clk_i);
		bus_o.rx_wr   = 1'b1;
		bus_o.rx_word = w;
		bus_o.rx_data = d;
		@(negedge clk_i);
		bus_o.rx_wr   = 1'b0;
		bus_o.rx_data = ~d;
	endtask
	// One fetch beat
	task tx;
		@(negedge clk_i);
		bus_o.tx_rd = 1'b1;
		@(negedge clk_i);
		bus_o.tx_rd = 1'b0;
	endtask
	task cfg(input logic c);
		bus_o.cs_en = c;
	endtask
endmodule

// ### test_parallel_port_data_regs.sv
// Bench: byte model per select compared with the block in every mode.
// Assumes package, design, checker and host model compile first.
`timescale 1ns/100ps
bind ppd_data_regs ppd_props u_props (.CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I), .MODE_I(MODE_I),
	.CORE_REQ_I(CORE_REQ_I), .BUS_REQ_I(BUS_REQ_I), .CORE_RDATA_O(CORE_RDATA_O),
	.BUS_ADDR_O(BUS_ADDR_O), .BUS_CS_O(BUS_CS_O), .BUS_TXDATA_O(BUS_TXDATA_O));
module test_parallel_port_data_regs;
	logic                   clk, rst_n, ms, bm;
	ppd_pkg::ppd_mode_t     mode;
	ppd_pkg::ppd_core_req_t core;
	ppd_pkg::ppd_bus_req_t  bus;
	logic [7:0]             rdata;
	logic [15:0]            addr, txd;
	logic [1:0]             cs;
	logic [7:0]             m [8]; // Model byte per select
	int                     failures, n_checks, rxb, txb;
	assign ms = mode == ppd_pkg::PPD_MODE_MASTER;
	assign bm = mode == ppd_pkg::PPD_MODE_BUF_SLAVE;
	ppd_host host (.clk_i(clk), .bus_o(bus));
	ppd_data_regs dut (.CLK_SYS_I(clk), .RESETN_I(rst_n), .MODE_I(mode), .CORE_REQ_I(core),
		.BUS_REQ_I(bus), .CORE_RDATA_O(rdata), .BUS_ADDR_O(addr), .BUS_CS_O(cs), .BUS_TXDATA_O(txd));
	////////////////////////////////////////
	task chk(input string n, input logic [15:0] e, g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	// Core byte write or read, one pulse
	task acc(input logic w, input int s, input logic [7:0] d);
		@(negedge clk);
		core = '{w, !w, ppd_pkg::ppd_sel_t'(s), d};
		@(negedge clk);
		core.wr = 1'b0;
		core.rd = 1'b0;
		if (w) m[s] = d;
		else chk("rdata", {8'h00, m[s]}, {8'h00, rdata});
	endtask
	// Buffered slave alternates A and B; others always A
	task brx(input logic w);
		logic [15:0] d;
		int i;
		d = 16'($urandom);
		i = bm && rxb ? 2 : 0;
		host.rx(w, d);
		m[i] = d[7:0];
		if (w) m[i+1] = d[15:8];
		if (bm) rxb = !rxb;
	endtask
	task btx;
		int i;
		i = ms ? 0 : (bm && txb) ? 6 : 4;
		host.tx();
		chk("txdata", {m[i+1], m[i]}, txd);
		if (bm) txb = !txb;
	endtask
	task adr(input logic c);
		host.cfg(c);
		acc(1, 5, 8'($urandom));
		chk("addr", ms ? {c ? 2'h0 : m[5][7:6], m[5][5:0], m[4]} : 16'h0000, addr);
		chk("cs", {14'h0, ms && c ? m[5][7:6] : 2'h0}, {14'h0, cs});
	endtask
	task summarize;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Watchdog far beyond the few hundred cycles needed
	initial begin
		#100000;
		failures++;
		summarize();
	end
	initial begin
		rst_n = 1'b0;
		mode = ppd_pkg::PPD_MODE_SLAVE;
		core = '0;
		void'($urandom(32'h48B4));
		foreach (m[s]) m[s] = 8'h00;
		repeat (12) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		for (int s = 0; s < 8; s++) acc(0, s, 8'h00);
		for (int k = 0; k < 3; k++) begin
			@(negedge clk);
			mode = ppd_pkg::ppd_mode_t'(k);
			rxb = 0;
			txb = 0;
			for (int s = 0; s < 8; s++) acc(1, s, 8'($urandom));
			for (int s = 0; s < 8; s++) acc(0, s, 8'h00);
			adr(0);
			adr(1);
			host.cfg(0);
			brx(1);
			btx();
			brx(1);
			brx(0);
			btx();
			for (int s = 0; s < 4; s++) acc(0, s, 8'h00);
			$display("mode %0d tests done", k);
		end
		summarize();
	end
endmodule
